// file: design/pss_sequencer.sv
/*
  Power sequencer top: brings up reference and internal LDO, then times the
  logic LDO, main boost and gate-on boost soft-starts, handles thermal
  shutdown with auto restart and drives the two discharge switches.
  Assumes analog comparators on SENSE, asynchronous to CLK_SYS; RESET is the
  undervoltage lockout of the sequencer's own supply.
*/
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire pss_pkg::pss_sense_type SENSE,
  output pss_pkg::pss_ctrl_type CTRL,
  output logic [pss_pkg::RAMP_W-1:0] LOGIC_LDO_TARGET,
  output logic [pss_pkg::RAMP_W-1:0] MAIN_BOOST_ILIMIT,
  output logic [pss_pkg::RAMP_W-1:0] GATE_ON_TARGET,
  output logic SEQ_DONE
);
  import pss_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int SW = $bits(pss_sense_type);
  logic [SW-1:0] sync_a, sync_b;
  pss_sense_type s;

  // Two stages; only the second is read by logic
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= SENSE;
      sync_b <= sync_a;
    end
  end
  assign s = pss_sense_type'(sync_b);

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  pss_state_type state, next_state;
  // Set once the input has cleared lockout, so a later drop is a power-down
  logic uv_seen, next_uv_seen;
  logic ramp_clear;
  logic logic_done, main_done, gate_done;
  logic main_start;
  logic gate_start;

  // Either supply above its coarse level can keep the reference alive
  function automatic logic supply_coarse(input pss_sense_type v);
    supply_coarse = v.input_supply_coarse || v.eeprom_supply_coarse;
  endfunction : supply_coarse

  // Lockout drops everything back toward start; fault has its own hold
  always_comb begin
    next_state = state;
    next_uv_seen = uv_seen;
    if (s.input_supply_uvlo_ok) begin
      next_uv_seen = 1'b1;
    end
    case (state)
      ST_OFF: begin
        // Reference comes up as soon as either supply can power it
        if (supply_coarse(s)) begin
          next_state = ST_REF;
        end
      end
      ST_REF: begin
        if (!supply_coarse(s)) begin
          next_state = ST_OFF;
        end else if (s.ref_ok) begin
          next_state = ST_LDO;
        end
      end
      ST_LDO: begin
        // Internal rail must pass its own lockout before the input check
        if (!supply_coarse(s)) begin
          next_state = ST_OFF;
        end else if (s.internal_ldo_rail_ok) begin
          next_state = ST_WAIT_UV;
        end
      end
      ST_WAIT_UV: begin
        // Heat is checked first: a hot part never starts a ramp
        if (s.over_temp) begin
          next_state = ST_FAULT;
        end else if (!s.internal_ldo_rail_ok) begin
          next_state = ST_LDO;
        end else if (s.input_supply_uvlo_ok) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (s.over_temp) begin
          next_state = ST_FAULT;
        end else if (!s.input_supply_uvlo_ok || !s.internal_ldo_rail_ok) begin
          next_state = ST_WAIT_UV;
        end
      end
      ST_FAULT: begin
        // Hysteresis comes from the sensor's recovered flag
        if (s.temp_recovered && !s.over_temp) begin
          next_state = ST_WAIT_UV;
        end
      end
      default: next_state = ST_OFF;
    endcase
    if (next_state == ST_RUN) begin
      next_uv_seen = 1'b1;
    end
  end

  // Register sequencer state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      state <= ST_OFF;
      uv_seen <= 1'b0;
    end else begin
      state <= next_state;
      uv_seen <= next_uv_seen;
    end
  end

  // ****************************************************************
  // Soft-start ramps
  // ****************************************************************
  // Any exit from run zeroes all ramps, so a restart is complete
  assign ramp_clear = (state != ST_RUN);
  // Main ramp holds at zero, and starts over, while the enable pin is low
  assign main_start = s.main_enable_pin;
  // Gate ramp drops in the same cycle as the main ramp, never after it
  assign gate_start = main_done && main_start;

  // Logic LDO voltage ramp
  pss_ramp #(.CYCLES(LOGIC_SS_CYC)) u_logic_ramp (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .CLEAR(ramp_clear),
    .START(1'b1),
    .LEVEL(LOGIC_LDO_TARGET),
    .DONE(logic_done)
  );

  // Main boost current-limit ramp
  pss_ramp #(.CYCLES(MAIN_SS_CYC)) u_main_ramp (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .CLEAR(ramp_clear),
    .START(main_start),
    .LEVEL(MAIN_BOOST_ILIMIT),
    .DONE(main_done)
  );

  // Gate-on voltage ramp waits on main completion
  pss_ramp #(.CYCLES(GATE_SS_CYC)) u_gate_ramp (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .CLEAR(ramp_clear),
    .START(gate_start),
    .LEVEL(GATE_ON_TARGET),
    .DONE(gate_done)
  );

  // ****************************************************************
  // Output controls
  // ****************************************************************
  pss_ctrl_type next_ctrl;
  logic next_seq_done;
  logic run;

  // Run is the only state in which any regulator other than the internal LDO rail may switch
  assign run = (state == ST_RUN);

  // Every enable except ref_en and internal_ldo_rail_en is gated by run, which excludes fault and lockout
  always_comb begin
    next_ctrl = '0;
    // Fault takes the reference down too; restart rechecks the rails
    next_ctrl.ref_en = (state != ST_OFF) && (state != ST_FAULT);
    next_ctrl.internal_ldo_rail_en = (state == ST_LDO) ||
        (state == ST_WAIT_UV) || run;
    next_ctrl.logic_ldo_output_en = run;
    next_ctrl.main_boost_en = run && s.main_enable_pin;
    next_ctrl.gate_on_en = run && main_done;
    next_ctrl.vcom_cal_en = run;
    next_ctrl.amp_out_en = run;
    // Only a real power-down after the input has cleared lockout, not the first startup
    next_ctrl.negative_rail_discharge = uv_seen &&
        !s.input_supply_uvlo_ok && (state != ST_FAULT);
    next_ctrl.gate_off_discharge = s.gate_off_discharge_input_low;
    next_ctrl.thermal_fault = (state == ST_FAULT);
    // The done flags are registered, so qualify with the live enable too
    next_seq_done = run && logic_done && gate_done && main_start;
  end

  // Register outputs
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      CTRL <= '0;
      SEQ_DONE <= 1'b0;
    end else begin
      CTRL <= next_ctrl;
      SEQ_DONE <= next_seq_done;
    end
  end
endmodule : pss_sequencer
`default_nettype wire

// file: design/pss_pkg.sv
/*
  Package for the panel supply power sequencer: timing counts, ramp widths,
  sequencer states and the grouped comparator and output carriers.
  Assumes a 25 MHz system clock.
*/
package pss_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 25000000;
  localparam int LOGIC_SS_MS = 3;
  localparam int MAIN_SS_MS = 13;
  localparam int GATE_SS_MS = 3;
  localparam int LOGIC_SS_CYC = LOGIC_SS_MS * (CLK_HZ / 1000);
  localparam int MAIN_SS_CYC = MAIN_SS_MS * (CLK_HZ / 1000);
  localparam int GATE_SS_CYC = GATE_SS_MS * (CLK_HZ / 1000);

  // ****************************************************************
  // Ramps
  // ****************************************************************
  localparam int RAMP_W = 8;
  localparam logic [RAMP_W-1:0] RAMP_ZERO = 8'h00;
  localparam logic [RAMP_W-1:0] RAMP_FULL = 8'hFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum {
    ST_OFF, ST_REF, ST_LDO, ST_WAIT_UV, ST_RUN, ST_FAULT
  } pss_state_type;

  // Comparator inputs, all asynchronous to the system clock
  typedef struct packed {
    logic input_supply_coarse;
    logic eeprom_supply_coarse;
    logic ref_ok;
    logic internal_ldo_rail_ok;
    logic input_supply_uvlo_ok;
    logic main_enable_pin;
    logic over_temp;
    logic temp_recovered;
    logic gate_off_discharge_input_low;
  } pss_sense_type;

  typedef struct packed {
    logic ref_en;
    logic internal_ldo_rail_en;
    logic logic_ldo_output_en;
    logic main_boost_en;
    logic gate_on_en;
    logic vcom_cal_en;
    logic amp_out_en;
    logic negative_rail_discharge;
    logic gate_off_discharge;
    logic thermal_fault;
  } pss_ctrl_type;

endpackage : pss_pkg

// file: design/pss_ramp.sv
/*
  Soft-start ramp: steps an output from zero to full over a fixed number of
  clock cycles once started. Assumes start is a synchronous level and clear
  returns it to zero at once.
*/
`timescale 1ns/1ps
`default_nettype none
module pss_ramp #(
  parameter int CYCLES = 75000
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic CLEAR,
  input wire logic START,
  output logic [pss_pkg::RAMP_W-1:0] LEVEL,
  output logic DONE
);
  import pss_pkg::*;

  // ****************************************************************
  // Step timing
  // ****************************************************************
  // Cycles per ramp step; the last step pads out the full period
  localparam int STEP = CYCLES / 255;
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] STEP_C = CW'(STEP - 1);
  localparam logic [CW-1:0] TOTAL_C = CW'(CYCLES - 1);

  logic [CW-1:0] total, next_total;
  logic [CW-1:0] step, next_step;
  logic [RAMP_W-1:0] next_level;
  logic next_done;

  // Next ramp values; reset to zero on clear
  always_comb begin
    next_total = total;
    next_step = step;
    next_level = LEVEL;
    next_done = DONE;
    if (CLEAR || !START) begin
      next_total = '0;
      next_step = '0;
      next_level = RAMP_ZERO;
      next_done = 1'b0;
    end else if (!DONE) begin
      if (total == TOTAL_C) begin
        next_done = 1'b1;
        next_level = RAMP_FULL; // Full only at period end
      end else begin
        next_total = total + 1'b1;
        if (step == STEP_C) begin
          next_step = '0;
          if (LEVEL != RAMP_FULL - 1'b1) begin
            next_level = LEVEL + 1'b1;
          end
        end else begin
          next_step = step + 1'b1;
        end
      end
    end
  end

  // Register the ramp state
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      total <= '0;
      step <= '0;
      LEVEL <= RAMP_ZERO;
      DONE <= 1'b0;
    end else begin
      total <= next_total;
      step <= next_step;
      LEVEL <= next_level;
      DONE <= next_done;
    end
  end
endmodule : pss_ramp
`default_nettype wire

// file: bench/pss_seq_properties.sv
/*
  Port checker for the power sequencer, bound to its top module.
  Assumes one clock domain and an asynchronous RESET.
*/
`timescale 1ns/1ps
`default_nettype none
module pss_seq_properties (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire pss_pkg::pss_sense_type SENSE,
  input wire pss_pkg::pss_ctrl_type CTRL,
  input wire logic [pss_pkg::RAMP_W-1:0] LOGIC_LDO_TARGET,
  input wire logic [pss_pkg::RAMP_W-1:0] MAIN_BOOST_ILIMIT,
  input wire logic [pss_pkg::RAMP_W-1:0] GATE_ON_TARGET,
  input wire logic SEQ_DONE
);
  import pss_pkg::*;
  // ****
  // Properties
  // ****
  // Reset clears every ramp, so no check runs inside it
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  a_ldo_after_ref: assert property (
    CTRL.internal_ldo_rail_en |-> CTRL.ref_en) else $error("ldo without ref");
  a_gate_after_main: assert property (
    GATE_ON_TARGET != 8'h00 |-> MAIN_BOOST_ILIMIT == 8'hFF)
    else $error("gate ramp early");
  a_logic_steps: assert property (
    $changed(LOGIC_LDO_TARGET) |-> LOGIC_LDO_TARGET == 8'h00 ||
    LOGIC_LDO_TARGET == $past(LOGIC_LDO_TARGET) + 8'h01)
    else $error("logic ramp jump");
  a_main_steps: assert property (
    $changed(MAIN_BOOST_ILIMIT) |-> MAIN_BOOST_ILIMIT == 8'h00 ||
    MAIN_BOOST_ILIMIT == $past(MAIN_BOOST_ILIMIT) + 8'h01)
    else $error("main ramp jump");
  a_main_needs_en: assert property (
    !SENSE.main_enable_pin [*5] |-> MAIN_BOOST_ILIMIT == 8'h00)
    else $error("main ramp while disabled");
  a_fault_all_off: assert property (
    CTRL.thermal_fault |-> !CTRL.logic_ldo_output_en && !CTRL.main_boost_en
    && !CTRL.gate_on_en && !CTRL.amp_out_en) else $error("output in fault");
  a_fault_ramps_zero: assert property (
    CTRL.thermal_fault && $past(CTRL.thermal_fault) |-> LOGIC_LDO_TARGET ==
    8'h00 && GATE_ON_TARGET == 8'h00) else $error("ramp in fault");
  a_goff_follow_on: assert property (
    SENSE.gate_off_discharge_input_low [*5] |-> CTRL.gate_off_discharge)
    else $error("gate-off switch open");
  a_goff_follow_off: assert property (
    !SENSE.gate_off_discharge_input_low [*5] |-> !CTRL.gate_off_discharge)
    else $error("gate-off switch closed");
  a_neg_only_down: assert property (
    SENSE.input_supply_uvlo_ok [*5] |-> !CTRL.negative_rail_discharge)
    else $error("negative rail shorted");
  a_uvlo_ldo_off: assert property (
    !SENSE.input_supply_uvlo_ok [*5] |-> LOGIC_LDO_TARGET == 8'h00 &&
    !CTRL.vcom_cal_en) else $error("ldo on in lockout");
  a_done_full: assert property (
    SEQ_DONE |-> GATE_ON_TARGET == 8'hFF) else $error("done early");
  // ****
  // Coverage
  // ****
  c_fault: cover property (CTRL.thermal_fault);
  c_logic_full: cover property (LOGIC_LDO_TARGET == 8'hFF);
  c_main_up: cover property (MAIN_BOOST_ILIMIT != 8'h00);
endmodule : pss_seq_properties
bind pss_sequencer pss_seq_properties u_props (.CLK_SYS(CLK_SYS),
  .RESET(RESET), .SENSE(SENSE), .CTRL(CTRL),
  .LOGIC_LDO_TARGET(LOGIC_LDO_TARGET), .MAIN_BOOST_ILIMIT(MAIN_BOOST_ILIMIT),
  .GATE_ON_TARGET(GATE_ON_TARGET), .SEQ_DONE(SEQ_DONE));
`default_nettype wire

// file: bench/pss_sequencer_tb_top.sv
/*
  Self-checking bench for the power sequencer.
  Assumes full-length ramps; the main ramp is only seen part way.
*/
`timescale 1ns/1ps
`default_nettype none
module pss_sequencer_tb_top;
  import pss_pkg::*;
  typedef struct packed {
    pss_sense_type sense;
    logic ref_en;
    logic goff;
  } pss_row_type;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  pss_sense_type sense = '0;
  pss_ctrl_type ctrl;
  logic [RAMP_W-1:0] lt, ml, gt;
  logic seq_done;
  pss_row_type rows [0:4];
  int num_errors = 0;
  int cmp_count = 0;
  // ****
  // Clock, design, helpers
  // ****
  always #20 clk_sys = ~clk_sys;
  pss_sequencer dut (.CLK_SYS(clk_sys), .RESET(reset), .SENSE(sense),
    .CTRL(ctrl), .LOGIC_LDO_TARGET(lt), .MAIN_BOOST_ILIMIT(ml),
    .GATE_ON_TARGET(gt), .SEQ_DONE(seq_done));
  task automatic chk(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  // Inputs move on the falling edge, clear of the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic close_out;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // ****
  // Tests
  // ****
  initial begin
    rows[0] = {9'h000, 1'b0, 1'b0};
    rows[1] = {9'h100, 1'b1, 1'b0};
    rows[2] = {9'h101, 1'b1, 1'b1};
    rows[3] = {9'h080, 1'b1, 1'b0};
    rows[4] = {9'h001, 1'b0, 1'b1};
    cyc(2);
    reset = 1'b0;
    foreach (rows[i]) begin
      sense = rows[i].sense;
      cyc(8);
      chk(ctrl.ref_en === rows[i].ref_en, "reference enable");
      chk(ctrl.gate_off_discharge === rows[i].goff, "gate-off");
    end
    // Full start; ramp steps every 294 cycles, main every 1274
    sense = 9'h178;
    cyc(3000);
    chk(lt inside {[8'h09:8'h0B]}, "logic ramp mid");
    chk(ctrl.negative_rail_discharge === 1'b0, "neg switch");
    cyc(72100);
    chk(lt === 8'hFF, "logic ramp end");
    chk(ml inside {[8'h39:8'h3C]}, "main ramp part");
    chk(gt === 8'h00 && seq_done === 1'b0, "gate early");
    chk(ctrl.main_boost_en === 1'b1, "main enable");
    sense.over_temp = 1'b1;
    cyc(8);
    chk(ctrl.thermal_fault === 1'b1 && lt === 8'h00, "fault");
    chk(ctrl.amp_out_en === 1'b0 && ml === 8'h00, "fault off");
    sense.over_temp = 1'b0;
    sense.temp_recovered = 1'b1;
    cyc(8);
    chk(ctrl.thermal_fault === 1'b0, "fault clear");
    cyc(1300);
    chk(lt !== 8'h00 && ml !== 8'h00, "restart");
    sense.temp_recovered = 1'b0;
    sense.input_supply_uvlo_ok = 1'b0;
    cyc(8);
    chk(ctrl.main_boost_en === 1'b0 && lt === 8'h00, "lockout");
    chk(ctrl.vcom_cal_en === 1'b0 && ctrl.amp_out_en === 1'b0, "amps");
    chk(ctrl.negative_rail_discharge === 1'b1, "neg short");
    // Restart with the main enable low: main ramp must wait
    sense.main_enable_pin = 1'b0;
    sense.input_supply_uvlo_ok = 1'b1;
    cyc(2000);
    chk(ml === 8'h00 && lt !== 8'h00, "main held");
    reset = 1'b1;
    cyc(2);
    chk(ctrl === '0 && lt === 8'h00, "mid reset");
    reset = 1'b0;
    cyc(1);
    chk(ctrl === '0 && seq_done === 1'b0, "after reset");
    close_out();
  end
  // Run needs about 3.1 ms; cut it at 3.6 ms
  initial begin
    #3_600_000;
    num_errors++;
    close_out();
  end
endmodule : pss_sequencer_tb_top
`default_nettype wire
